/* File: mbox_cmd_pkg.sv */
package mbox_cmd_pkg;
	localparam int NCH = 8;
	localparam logic [7:0] ADR_CMD_WORD = 8'h00;
	localparam logic [7:0] ADR_REPLY_WORD = 8'h04;
	localparam logic [7:0] CMD_CLR_ECHO = 8'h00;
	localparam logic [7:0] CMD_MATCH_IRQ_EN = 8'h2b;
	localparam logic [7:0] CMD_MATCH_FIRST = 8'h48;
	localparam logic [7:0] CMD_MATCH_LAST = 8'h4f;
	localparam logic [7:0] CMD_RD_IRQ_FLAGS = 8'h60;
	localparam logic [7:0] CMD_RD_EDGE_FLAGS = 8'h61;
	localparam logic [7:0] CMD_RD_CNT_FLAGS = 8'h62;
	localparam logic [7:0] TOP_BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [4:0] IRQ_RSVD_ZERO = 5'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam int IRQ_PAT_BIT = 0;
	localparam int IRQ_COS_BIT = 1;
	localparam int IRQ_CNT_BIT = 2;
	typedef logic [NCH-1:0][15:0] cnt_arr_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;
	typedef struct packed {
		logic [7:0] host_out_byte3;
		logic [7:0] host_out_cmd_byte;
		logic [7:0] host_out_byte1;
		logic [7:0] host_out_byte0;
	} host_cmd_t;
	typedef struct packed {
		logic [7:0] card_reply_input_levels;
		logic [7:0] card_reply_echo_byte;
		logic [7:0] card_reply_byte1;
		logic [7:0] card_reply_byte0;
	} card_reply_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rd;
		host_cmd_t cmd;
		card_reply_t reply;
		cnt_arr_t match_val;
		logic [NCH-1:0] match_irq_en;
		logic [NCH-1:0] last_in;
		logic primed;
		logic [NCH-1:0] rise;
		logic [NCH-1:0] fall;
		logic [NCH-1:0] ovf;
		logic [NCH-1:0] hit;
		logic [NCH-1:0] eq_prev;
		logic [2:0] irq_flags;
		logic irq;
	} state_t;
	localparam state_t STATE_RST = '0;
endpackage

/* File: input_counter_flag_commands.sv */
`timescale 1ns/1ps
// Operation
// - Match value command: top byte zero, code, high byte, low byte; value 256*high+low
// - Eight stored sixteen-bit match values, code 48h plus n selects channel n
// - Reply carries present input levels on top byte and echoed code below
// - Channel with counter and match interrupt enabled whose counter reaches its match value raises an interrupt
// - Match value write ignored for a channel whose counter is not enabled
// - Flag read 60h: bit0 pattern, bit1 change of state, bit2 counter event
// - Any flag bit set means an interrupt was signalled to the system
// - Edge read 61h: byte1 bit n set when last change was falling
// - Edge read 61h: byte0 bit n set when last change was rising
// - Edge reply bit n belongs to input channel n
// - Counter read 62h: byte1 bit n set when counter n overflowed
// - Counter read 62h: byte0 bit n set when counter n hit match
// - Code zero clears the echo byte to zero
// - Code 2Bh sets the per-channel match interrupt enables
module input_counter_flag_commands (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire mbox_cmd_pkg::wb_req_t wb_req_i,
	output mbox_cmd_pkg::wb_rsp_t wb_rsp_o,
	input wire logic [7:0] isolated_input_i,
	input wire logic [7:0] counter_enable_i,
	input wire mbox_cmd_pkg::cnt_arr_t counter_value_i,
	input wire logic [7:0] counter_overflow_i,
	input wire logic counter_ovf_irq_i,
	input wire logic pattern_irq_i,
	input wire logic cos_irq_i,
	output logic match_irq_o
);
	import mbox_cmd_pkg::*;

	state_t q;
	state_t d;
	host_cmd_t cmdw;
	logic cmd_go;
	logic [2:0] ch;
	logic [NCH-1:0] eq;
	logic [NCH-1:0] hit_ev;
	logic [NCH-1:0] rise_ev;
	logic [NCH-1:0] fall_ev;
	logic clr_irq;
	logic clr_cnt;
	logic match_irq_ev;

	function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_match_cmd(input logic [7:0] code);
		return (code >= CMD_MATCH_FIRST) && (code <= CMD_MATCH_LAST);
	endfunction

	always_comb begin
		d = q;
		clr_irq = 1'b0;
		clr_cnt = 1'b0;
		// Bus slave: one wait state, ack for one cycle
		d.ack = wb_req_i.cyc && wb_req_i.stb && !q.ack;
		case (wb_req_i.adr)
			ADR_CMD_WORD: d.rd = q.cmd;
			ADR_REPLY_WORD: d.rd = q.reply;
			default: d.rd = WORD_ZERO;
		endcase
		cmdw = lane_merge(q.cmd, wb_req_i.dat, wb_req_i.sel);
		cmd_go = d.ack && wb_req_i.we && (wb_req_i.adr == ADR_CMD_WORD);
		ch = cmdw.host_out_cmd_byte[2:0];
		if (cmd_go) begin
			d.cmd = cmdw;
		end
		// Command execution
		if (cmd_go && (cmdw.host_out_byte3 == TOP_BYTE_ZERO)) begin
			case (cmdw.host_out_cmd_byte)
				CMD_CLR_ECHO: begin
					d.reply.card_reply_input_levels = isolated_input_i;
					d.reply.card_reply_echo_byte = BYTE_ZERO;
					d.reply.card_reply_byte1 = BYTE_ZERO;
					d.reply.card_reply_byte0 = BYTE_ZERO;
				end
				CMD_MATCH_IRQ_EN: begin
					d.match_irq_en = cmdw.host_out_byte0;
					d.reply = '{isolated_input_i, cmdw.host_out_cmd_byte,
						BYTE_ZERO, BYTE_ZERO};
				end
				CMD_RD_IRQ_FLAGS: begin
					d.reply = '{isolated_input_i, cmdw.host_out_cmd_byte,
						BYTE_ZERO, {IRQ_RSVD_ZERO, q.irq_flags}};
					clr_irq = 1'b1;
				end
				CMD_RD_EDGE_FLAGS: begin
					d.reply = '{isolated_input_i, cmdw.host_out_cmd_byte,
						q.fall, q.rise};
				end
				CMD_RD_CNT_FLAGS: begin
					d.reply = '{isolated_input_i, cmdw.host_out_cmd_byte,
						q.ovf, q.hit};
					clr_cnt = 1'b1;
				end
				default: begin
					if (is_match_cmd(cmdw.host_out_cmd_byte)) begin
						if (counter_enable_i[ch]) begin
							d.match_val[ch] = {cmdw.host_out_byte1,
								cmdw.host_out_byte0};
						end
						d.reply = '{isolated_input_i, cmdw.host_out_cmd_byte,
							BYTE_ZERO, BYTE_ZERO};
					end
				end
			endcase
		end
		// Edge direction tracking, bit n is channel n
		rise_ev = q.primed ? (isolated_input_i & ~q.last_in) : '0;
		fall_ev = q.primed ? (~isolated_input_i & q.last_in) : '0;
		d.rise = (q.rise & ~fall_ev) | rise_ev;
		d.fall = (q.fall & ~rise_ev) | fall_ev;
		d.last_in = isolated_input_i;
		d.primed = 1'b1;
		// Match detection on enabled counters
		for (int i = 0; i < NCH; i++) begin
			eq[i] = counter_enable_i[i] &&
				(counter_value_i[i] == q.match_val[i]);
		end
		hit_ev = eq & ~q.eq_prev;
		d.eq_prev = eq;
		match_irq_ev = |(hit_ev & q.match_irq_en);
		d.irq = match_irq_ev;
		// Sticky flags, set wins over read clear
		d.hit = (q.hit & ~{NCH{clr_cnt}}) | hit_ev;
		d.ovf = (q.ovf & ~{NCH{clr_cnt}}) | counter_overflow_i;
		d.irq_flags = q.irq_flags & ~{3{clr_irq}};
		d.irq_flags[IRQ_PAT_BIT] = d.irq_flags[IRQ_PAT_BIT] | pattern_irq_i;
		d.irq_flags[IRQ_COS_BIT] = d.irq_flags[IRQ_COS_BIT] | cos_irq_i;
		d.irq_flags[IRQ_CNT_BIT] = d.irq_flags[IRQ_CNT_BIT] |
			counter_ovf_irq_i | match_irq_ev;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			q <= STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign wb_rsp_o = '{ack: q.ack, dat: q.rd};
	assign match_irq_o = q.irq;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_go(logic [7:0] code);
		cmd_go && (cmdw.host_out_byte3 == TOP_BYTE_ZERO) &&
			(cmdw.host_out_cmd_byte == code);
	endsequence

	sequence s_match_go;
		cmd_go && (cmdw.host_out_byte3 == TOP_BYTE_ZERO) &&
			is_match_cmd(cmdw.host_out_cmd_byte);
	endsequence

	property p_match_store;
		s_match_go ##0 counter_enable_i[ch] |=>
			q.match_val[$past(ch)] == {$past(cmdw.host_out_byte1),
				$past(cmdw.host_out_byte0)};
	endproperty
	a_match_store: assert property (p_match_store)
		else $error("match value not stored");

	property p_match_blocked;
		s_match_go ##0 !counter_enable_i[ch] |=> $stable(q.match_val);
	endproperty
	a_match_blocked: assert property (p_match_blocked)
		else $error("match value changed on disabled counter");

	property p_echo;
		s_match_go |=> q.ack && (q.reply.card_reply_echo_byte ==
			$past(cmdw.host_out_cmd_byte)) &&
			(q.reply.card_reply_input_levels == $past(isolated_input_i));
	endproperty
	a_echo: assert property (p_echo)
		else $error("reply echo or levels wrong");

	property p_match_irq;
		(|(hit_ev & q.match_irq_en)) |=> match_irq_o &&
			q.irq_flags[IRQ_CNT_BIT];
	endproperty
	a_match_irq: assert property (p_match_irq)
		else $error("match interrupt missing");

	property p_irq_read;
		s_go(CMD_RD_IRQ_FLAGS) |=> q.reply.card_reply_byte0 ==
			{IRQ_RSVD_ZERO, $past(q.irq_flags)};
	endproperty
	a_irq_read: assert property (p_irq_read)
		else $error("interrupt flag reply wrong");

	property p_pat_flag;
		pattern_irq_i |=> q.irq_flags[IRQ_PAT_BIT];
	endproperty
	a_pat_flag: assert property (p_pat_flag)
		else $error("pattern flag not set");

	property p_edge_read;
		s_go(CMD_RD_EDGE_FLAGS) |=> (q.reply.card_reply_byte1 ==
			$past(q.fall)) && (q.reply.card_reply_byte0 == $past(q.rise));
	endproperty
	a_edge_read: assert property (p_edge_read)
		else $error("edge flag reply wrong");

	property p_rise0;
		q.primed && isolated_input_i[0] && !q.last_in[0] |=>
			q.rise[0] && !q.fall[0];
	endproperty
	a_rise0: assert property (p_rise0)
		else $error("channel 0 rise not tracked");

	property p_cnt_read;
		s_go(CMD_RD_CNT_FLAGS) |=> (q.reply.card_reply_byte1 ==
			$past(q.ovf)) && (q.reply.card_reply_byte0 == $past(q.hit));
	endproperty
	a_cnt_read: assert property (p_cnt_read)
		else $error("counter flag reply wrong");

	property p_clr_echo;
		s_go(CMD_CLR_ECHO) |=> q.reply.card_reply_echo_byte == BYTE_ZERO;
	endproperty
	a_clr_echo: assert property (p_clr_echo)
		else $error("echo byte not cleared");

	property p_irq_en;
		s_go(CMD_MATCH_IRQ_EN) |=>
			q.match_irq_en == $past(cmdw.host_out_byte0);
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("match interrupt enable not stored");

	property p_ack_pulse;
		wb_req_i.cyc && wb_req_i.stb && !q.ack |=> q.ack ##1 !q.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("bus ack not a single pulse");

	property p_ovf_flag;
		(|counter_overflow_i) |=> (q.ovf & $past(counter_overflow_i)) ==
			$past(counter_overflow_i);
	endproperty
	a_ovf_flag: assert property (p_ovf_flag)
		else $error("overflow flag not set");

	property p_hit_flag;
		(|hit_ev) |=> (q.hit & $past(hit_ev)) == $past(hit_ev);
	endproperty
	a_hit_flag: assert property (p_hit_flag)
		else $error("match flag not set");

	property p_hit_clr;
		s_go(CMD_RD_CNT_FLAGS) ##0
			(!(|hit_ev) && !(|counter_overflow_i)) |=>
			(q.hit == '0) && (q.ovf == '0);
	endproperty
	a_hit_clr: assert property (p_hit_clr)
		else $error("counter flags not cleared by read");

	property p_cos_flag;
		cos_irq_i |=> q.irq_flags[IRQ_COS_BIT];
	endproperty
	a_cos_flag: assert property (p_cos_flag)
		else $error("change of state flag not set");

	property p_cnt_flag;
		counter_ovf_irq_i |=> q.irq_flags[IRQ_CNT_BIT];
	endproperty
	a_cnt_flag: assert property (p_cnt_flag)
		else $error("counter interrupt flag not set");

	property p_rsvd_zero;
		s_go(CMD_RD_IRQ_FLAGS) |=>
			q.reply.card_reply_byte0[7:3] == IRQ_RSVD_ZERO;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("undefined flag bits not zero");

	property p_fall7;
		q.primed && !isolated_input_i[7] && q.last_in[7] |=>
			q.fall[7] && !q.rise[7];
	endproperty
	a_fall7: assert property (p_fall7)
		else $error("channel 7 fall not tracked");

	property p_refused;
		cmd_go && (cmdw.host_out_byte3 != TOP_BYTE_ZERO) |=>
			$stable(q.reply) && $stable(q.match_val) &&
			$stable(q.match_irq_en);
	endproperty
	a_refused: assert property (p_refused)
		else $error("command with nonzero top byte executed");

	property p_irq_gate;
		!(|(hit_ev & q.match_irq_en)) |=> !match_irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("match interrupt without enabled match");

	property p_edge_echo;
		s_go(CMD_RD_EDGE_FLAGS) |=>
			(q.reply.card_reply_echo_byte == CMD_RD_EDGE_FLAGS) &&
			(q.reply.card_reply_input_levels == $past(isolated_input_i));
	endproperty
	a_edge_echo: assert property (p_edge_echo)
		else $error("edge read echo or levels wrong");
endmodule

/* File: cnt_model.sv */
`timescale 1ns/1ps
module cnt_model (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic go_i,
	input wire logic [7:0] en_i,
	output mbox_cmd_pkg::cnt_arr_t value_o,
	output logic [7:0] ovf_o
);
	import mbox_cmd_pkg::*;
	// Up counters, one per channel, counting only while enabled
	always_ff @(posedge ref_clk_i) begin
		for (int n = 0; n < NCH; n++) begin
			ovf_o[n] <= 1'b0;
			if (!rst_b_i) begin
				value_o[n] <= {8'hf8 | 8'(n), 8'h00};
			end else if (go_i && en_i[n]) begin
				value_o[n] <= value_o[n] + 16'h0001;
				ovf_o[n] <= (value_o[n] == 16'hffff);
			end
		end
	end
endmodule

/* File: tb_input_counter_flag_commands.sv */
`timescale 1ns/1ps
module tb_input_counter_flag_commands;
	import mbox_cmd_pkg::*;
	logic ref_clk_i = 0, rst_b_i = 0, go = 0, pat = 0, cos = 0, irq;
	wb_req_t req = '0;
	wb_rsp_t rsp;
	logic [7:0] lv = 8'h00, en = 8'h00, ovf, c, rise = 0, fall = 0;
	cnt_arr_t val;
	logic [15:0] m;
	logic [32:0] q[$];
	logic [32:0] mon_e;
	int err_total = 0, checks = 0, seed = 66260, irqs = 0;
	input_counter_flag_commands input_counter_flag_commands_i (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wb_req_i(req),
		.wb_rsp_o(rsp), .isolated_input_i(lv), .counter_enable_i(en),
		.counter_value_i(val), .counter_overflow_i(ovf),
		.counter_ovf_irq_i(|ovf), .pattern_irq_i(pat), .cos_irq_i(cos),
		.match_irq_o(irq));
	cnt_model cnt_model_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.go_i(go), .en_i(en), .value_o(val), .ovf_o(ovf));
	initial forever #4 ref_clk_i = ~ref_clk_i;
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic k, input logic [31:0] e);
		q.push_back({k, e});
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		do @(posedge ref_clk_i); while (rsp.ack !== 1'b1);
		req <= '0;
		@(posedge ref_clk_i);
	endtask
	task automatic op(input logic [7:0] k, input logic [15:0] p,
			input logic [31:0] e);
		bus(1'b1, ADR_CMD_WORD, {TOP_BYTE_ZERO, k, p}, 1'b0, 0);
		bus(1'b0, ADR_REPLY_WORD, WORD_ZERO, 1'b1, e);
	endtask
	task automatic setlv(input logic [7:0] v);
		rise = (rise & ~(lv ^ v)) | (v & ~lv);
		fall = (fall & ~(lv ^ v)) | (~v & lv);
		lv <= v;
		repeat (2) @(posedge ref_clk_i);
	endtask
	always @(posedge ref_clk_i) begin
		if (irq === 1'b1) irqs++;
		if (rsp.ack === 1'b1) begin
			mon_e = q.pop_front();
			if (mon_e[32]) chk("reply", rsp.dat, mon_e[31:0]);
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		@(posedge ref_clk_i);
		bus(1'b0, ADR_REPLY_WORD, WORD_ZERO, 1'b1, WORD_ZERO);
		setlv(8'($random(seed)));
		en <= 8'hdf;
		op(CMD_MATCH_IRQ_EN, 16'h007f, {lv, CMD_MATCH_IRQ_EN, 16'h0});
		for (int n = 0; n < NCH; n++) begin
			m = val[n] + 16'(8 + 4 * n) + 16'($random(seed) & 3);
			if (n == 5) m = val[5];
			c = CMD_MATCH_FIRST + 8'(n);
			op(c, m, {lv, c, 16'h0});
		end
		go <= 1'b1;
		repeat (48) @(posedge ref_clk_i);
		go <= 1'b0;
		en <= 8'hff;
		repeat (8) @(posedge ref_clk_i);
		chk("match irq count", 32'(irqs), 32'd6);
		op(CMD_RD_CNT_FLAGS, 16'($random(seed)),
			{lv, CMD_RD_CNT_FLAGS, 16'h00df});
		op(CMD_RD_IRQ_FLAGS, 16'($random(seed)),
			{lv, CMD_RD_IRQ_FLAGS, 16'h0004});
		$display("test match done");
		go <= 1'b1;
		repeat (260) @(posedge ref_clk_i);
		go <= 1'b0;
		op(CMD_RD_CNT_FLAGS, 16'h0, {lv, CMD_RD_CNT_FLAGS, 16'h8000});
		pat <= 1'b1;
		@(posedge ref_clk_i);
		pat <= 1'b0;
		cos <= 1'b1;
		@(posedge ref_clk_i);
		cos <= 1'b0;
		op(CMD_RD_IRQ_FLAGS, 16'h0, {lv, CMD_RD_IRQ_FLAGS, 16'h0007});
		$display("test flags done");
		for (int k = 0; k < 4; k++) begin
			setlv(8'($random(seed)));
			op(CMD_RD_EDGE_FLAGS, 16'($random(seed)),
				{lv, CMD_RD_EDGE_FLAGS, fall, rise});
		end
		bus(1'b1, ADR_CMD_WORD, {8'h01, CMD_CLR_ECHO, 16'h0}, 1'b0, 0);
		bus(1'b0, ADR_REPLY_WORD, 0, 1'b1,
			{lv, CMD_RD_EDGE_FLAGS, fall, rise});
		m = 16'($random(seed));
		op(CMD_CLR_ECHO, m, {lv, 24'h0});
		bus(1'b0, ADR_CMD_WORD, WORD_ZERO, 1'b1,
			{TOP_BYTE_ZERO, CMD_CLR_ECHO, m});
		$display("test edges and echo done");
		tally_and_finish();
	end
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		err_total++;
		tally_and_finish();
	end
endmodule
